//--- hw/omm_pkg.sv
// Purpose: Shared constants and types of the optical module management port.
// Assumes: 50 MHz system clock; two-wire bus clocked by the host.
// Notes:   Memory map contents beyond the monitor and flag bytes are generic.
package omm_pkg;

  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int unsigned TX_SWITCH_MS     = 100;
  localparam int unsigned TX_SWITCH_CYCLES =
    (TX_SWITCH_MS * (CLK_HZ / 1000));
  localparam int unsigned DATA_W           = 8;

  // Memory map of the monitor block.
  localparam logic [7:0] ADDR_TEMP    = 8'h00;
  localparam logic [7:0] ADDR_BIAS    = 8'h01;
  localparam logic [7:0] ADDR_TXPWR   = 8'h02;
  localparam logic [7:0] ADDR_RXPWR   = 8'h03;
  localparam logic [7:0] ADDR_VCC     = 8'h04;
  localparam logic [7:0] ADDR_ALARM   = 8'h05;
  localparam logic [7:0] ADDR_WARN    = 8'h06;
  localparam logic [7:0] ADDR_STATUS  = 8'h07;
  localparam logic [7:0] ADDR_WP_TOP  = 8'h7F;
  localparam logic [6:0] DEV_ADDR     = 7'h50;
  localparam int unsigned N_MON       = 5;

  typedef struct packed {
    logic [7:0] temp;
    logic [7:0] bias;
    logic [7:0] txpwr;
    logic [7:0] rxpwr;
    logic [7:0] vcc;
  } omm_mon_s;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } omm_limit_s;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_REG  = 6'b000100,
    ST_WR   = 6'b001000,
    ST_RD   = 6'b010000,
    ST_ACK  = 6'b100000
  } omm_twi_e;

endpackage

//--- hw/omm_twi_slave.sv
// Purpose: Two-wire serial slave running on the host-made serial clock.
// Assumes: Host drives the serial clock and frames with start and stop.
// Notes:   State is held between frames; a stop or start ends the frame.
`timescale 1ns/1ps
module omm_twi_slave (
  // Link clock and reset
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic        nrst_in,
  input  wire logic        selected_in,
  // Data line drive
  output logic             sda_oe_n_out,
  // Memory access in the serial clock domain
  output logic [7:0]       mem_addr_out,
  output logic [7:0]       mem_wdata_out,
  output logic             mem_wr_tgl_out,
  input  wire logic [7:0]  mem_rdata_in
);

  omm_pkg::omm_twi_e state;
  omm_pkg::omm_twi_e last;
  logic [7:0] shift;
  logic [7:0] byte_in;
  logic [2:0] bitcnt;
  logic       rw;
  logic       ack_ok;
  logic       host_slot;
  logic       start_tgl;
  logic       stop_tgl;
  logic       start_seen;
  logic       stop_seen;
  logic       frame_rst_n;

  // Start and stop are data edges while the clock is high.
  always_ff @(negedge sda_in or negedge nrst_in) begin
    if (!nrst_in) start_tgl <= 1'b0;
    else if (scl_in) start_tgl <= ~start_tgl;
  end
  always_ff @(posedge sda_in or negedge nrst_in) begin
    if (!nrst_in) stop_tgl <= 1'b0;
    else if (scl_in) stop_tgl <= ~stop_tgl;
  end

  // The start flag is seen on the next clock rise; no free clock exists.
  logic start_ack;
  logic stop_ack;
  always_ff @(posedge scl_in or negedge nrst_in) begin
    if (!nrst_in) begin
      start_ack <= 1'b0;
      stop_ack  <= 1'b0;
    end else begin
      start_ack <= start_tgl;
      stop_ack  <= stop_tgl;
    end
  end
  assign start_seen  = start_ack != start_tgl;
  assign stop_seen   = stop_ack != stop_tgl;
  assign frame_rst_n = nrst_in;
  assign byte_in     = {shift[6:0], sda_in};

  // Receive side: sample on the rising clock edge. The byte is decided at
  // its eighth rise so that the acknowledge can be driven on the next fall.
  always_ff @(posedge scl_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      state          <= omm_pkg::ST_IDLE;
      last           <= omm_pkg::ST_IDLE;
      shift          <= 8'h00;
      bitcnt         <= 3'h0;
      rw             <= 1'b0;
      ack_ok         <= 1'b0;
      host_slot      <= 1'b0;
      mem_addr_out   <= 8'h00;
      mem_wdata_out  <= 8'h00;
      mem_wr_tgl_out <= 1'b0;
    end else if (start_seen) begin
      state  <= omm_pkg::ST_ADDR;
      shift  <= {7'h00, sda_in};
      bitcnt <= 3'h1;
    end else if (stop_seen) begin
      state <= omm_pkg::ST_IDLE;
    end else begin
      case (state)
        omm_pkg::ST_ADDR, omm_pkg::ST_REG, omm_pkg::ST_WR: begin
          shift  <= byte_in;
          bitcnt <= bitcnt + 3'h1;
          if (bitcnt == 3'h7) begin
            state     <= omm_pkg::ST_ACK;
            last      <= state;
            host_slot <= 1'b0;
            ack_ok    <= 1'b1;
            if (state == omm_pkg::ST_ADDR) begin
              rw     <= byte_in[0];
              ack_ok <= (byte_in[7:1] == omm_pkg::DEV_ADDR)
                        && selected_in;
            end else if (state == omm_pkg::ST_REG) begin
              mem_addr_out <= byte_in;
            end else begin
              mem_wdata_out  <= byte_in;
              mem_wr_tgl_out <= ~mem_wr_tgl_out;
            end
          end
        end
        omm_pkg::ST_ACK: begin
          bitcnt <= 3'h0;
          if (host_slot) begin
            // A nack from the host ends the read.
            state <= sda_in ? omm_pkg::ST_IDLE : omm_pkg::ST_RD;
          end else if (!ack_ok) begin
            state <= omm_pkg::ST_IDLE;
          end else if (last == omm_pkg::ST_ADDR) begin
            state <= rw ? omm_pkg::ST_RD : omm_pkg::ST_REG;
          end else if (last == omm_pkg::ST_WR) begin
            state        <= omm_pkg::ST_WR;
            mem_addr_out <= mem_addr_out + 8'h01;
          end else begin
            state <= omm_pkg::ST_WR;
          end
        end
        omm_pkg::ST_RD: begin
          bitcnt <= bitcnt + 3'h1;
          if (bitcnt == 3'h7) begin
            state     <= omm_pkg::ST_ACK;
            last      <= omm_pkg::ST_RD;
            host_slot <= 1'b1;
            // Advancing early gives the core a whole bit to fetch the next
            // byte; a final nack merely leaves the address one ahead.
            mem_addr_out <= mem_addr_out + 8'h01;
          end
        end
        default: state <= omm_pkg::ST_IDLE;
      endcase
    end
  end

  // Transmit side: the data line changes on the falling clock edge.
  always_ff @(negedge scl_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      sda_oe_n_out <= 1'b1;
    end else begin
      case (state)
        omm_pkg::ST_ACK: sda_oe_n_out <= host_slot | ~ack_ok;
        omm_pkg::ST_RD:
          sda_oe_n_out <= mem_rdata_in[3'h7 - bitcnt];
        default: sda_oe_n_out <= 1'b1;
      endcase
    end
  end

endmodule

//--- hw/omm_top.sv
// Purpose: Management and low-speed control side of the optical module.
// Assumes: 50 MHz core clock; host-made serial clock as a second domain.
// Notes:   Write-protected span is the low part of the memory map.
`timescale 1ns/1ps
module omm_top #(
  parameter int unsigned TX_SWITCH_CYCLES = omm_pkg::TX_SWITCH_CYCLES,
  parameter int unsigned MEM_DEPTH        = 256
) (
  // Clock and reset
  input  wire logic                 ref_clk_in,
  input  wire logic                 nrst_in,
  // Low-speed control pins
  input  wire logic                 deselect_in,
  input  wire logic                 transmitter_off_in,
  input  wire logic                 power_down_in,
  input  wire logic                 optical_signal_in,
  input  wire omm_pkg::omm_mon_s    monitor_in,
  input  wire omm_pkg::omm_limit_s  limits_in [omm_pkg::N_MON],
  // Two-wire bus
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe_n_out,
  // Status pins
  output logic                      interrupt_n_out,
  output logic                      module_absent_out,
  output logic                      receive_signal_lost_out,
  output logic                      laser_on_out,
  output logic                      standby_out
);

  initial begin
    if (MEM_DEPTH != 256) $error("MEM_DEPTH must be 256");
    if (TX_SWITCH_CYCLES < 1) $error("TX_SWITCH_CYCLES must be >= 1");
  end

  localparam int unsigned CW = $clog2(TX_SWITCH_CYCLES + 1);

  // Pin synchronisers.
  logic [1:0] desel_s, txoff_s, pd_s, sig_s;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      desel_s <= 2'h3;
      txoff_s <= 2'h3;
      pd_s    <= 2'h3;
      sig_s   <= 2'h0;
    end else begin
      desel_s <= {desel_s[0], deselect_in};
      txoff_s <= {txoff_s[0], transmitter_off_in};
      pd_s    <= {pd_s[0], power_down_in};
      sig_s   <= {sig_s[0], optical_signal_in};
    end
  end

  // Power-down edge detect and module reset pulse.
  logic pd_prev;
  logic core_rst_n;
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pd_prev    <= 1'b1;
      core_rst_n <= 1'b0;
    end else begin
      pd_prev    <= pd_s[1];
      core_rst_n <= !(pd_prev && !pd_s[1]) && !pd_s[1];
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) standby_out <= 1'b1;
    else standby_out <= pd_s[1];
  end

  // The serial clock stands still between frames, so a reset chain on it
  // would miss the first start; the core reset is applied directly, which
  // is safe because it releases while the serial clock is idle high.
  // Selection crosses into the serial domain as a level.
  logic [1:0] sel_s;
  always_ff @(posedge scl_in or negedge core_rst_n) begin
    if (!core_rst_n) sel_s <= 2'h0;
    else sel_s <= {sel_s[0], ~deselect_in};
  end

  logic [7:0] twi_addr;
  logic [7:0] twi_wdata;
  logic       twi_wr_tgl;
  logic [7:0] twi_rdata;
  logic       sda_oe_n;

  omm_twi_slave u_twi (
    .scl_in         (scl_in),
    .sda_in         (sda_in),
    .nrst_in        (core_rst_n),
    .selected_in    (sel_s[1]),
    .sda_oe_n_out   (sda_oe_n),
    .mem_addr_out   (twi_addr),
    .mem_wdata_out  (twi_wdata),
    .mem_wr_tgl_out (twi_wr_tgl),
    .mem_rdata_in   (twi_rdata)
  );

  // Write toggle crosses to the core clock; address and data are stable.
  logic [2:0] wr_s;
  always_ff @(posedge ref_clk_in or negedge core_rst_n) begin
    if (!core_rst_n) wr_s <= 3'h0;
    else wr_s <= {wr_s[1:0], twi_wr_tgl};
  end
  logic wr_pulse;
  assign wr_pulse = wr_s[2] ^ wr_s[1];

  // Byte memory with live monitor and flag bytes.
  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] alarm, warn;
  omm_pkg::omm_mon_s mon_q;
  logic [7:0] mon_v [omm_pkg::N_MON];

  always_ff @(posedge ref_clk_in or negedge core_rst_n) begin
    if (!core_rst_n) mon_q <= '0;
    else mon_q <= monitor_in;
  end
  assign mon_v[0] = mon_q.temp;
  assign mon_v[1] = mon_q.bias;
  assign mon_v[2] = mon_q.txpwr;
  assign mon_v[3] = mon_q.rxpwr;
  assign mon_v[4] = mon_q.vcc;

  function automatic logic out_of(input logic [7:0] v,
                                  input logic [7:0] lo,
                                  input logic [7:0] hi);
    out_of = (v < lo) || (v > hi);
  endfunction

  always_ff @(posedge ref_clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      alarm <= 8'h00;
      warn  <= 8'h00;
    end else begin
      for (int i = 0; i < omm_pkg::N_MON; i++) begin
        // Alarms use the outer limits; warnings raise the low limit by a quarter and lower the high limit by an eighth.
        alarm[i] <= out_of(mon_v[i], limits_in[i].lo, limits_in[i].hi);
        warn[i]  <= out_of(mon_v[i], limits_in[i].lo + (limits_in[i].lo >> 2),
                           limits_in[i].hi - (limits_in[i].hi >> 3));
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      for (int i = 0; i < MEM_DEPTH; i++) mem[i] <= 8'h00;
    end else if (wr_pulse && twi_addr > omm_pkg::ADDR_WP_TOP) begin
      mem[twi_addr] <= twi_wdata;
    end
  end

  logic [7:0] rd_core;
  always_comb begin
    case (twi_addr)
      omm_pkg::ADDR_TEMP:   rd_core = mon_q.temp;
      omm_pkg::ADDR_BIAS:   rd_core = mon_q.bias;
      omm_pkg::ADDR_TXPWR:  rd_core = mon_q.txpwr;
      omm_pkg::ADDR_RXPWR:  rd_core = mon_q.rxpwr;
      omm_pkg::ADDR_VCC:    rd_core = mon_q.vcc;
      omm_pkg::ADDR_ALARM:  rd_core = alarm;
      omm_pkg::ADDR_WARN:   rd_core = warn;
      omm_pkg::ADDR_STATUS: rd_core = {5'h00, ~laser_on_out,
                                       receive_signal_lost_out, standby_out};
      default:              rd_core = mem[twi_addr];
    endcase
  end

  // Read byte is registered on the core clock, then re-timed on the serial
  // clock; the host holds the clock low long enough for it to settle.
  logic [7:0] rd_q;
  always_ff @(posedge ref_clk_in or negedge core_rst_n) begin
    if (!core_rst_n) rd_q <= 8'h00;
    else rd_q <= rd_core;
  end
  always_ff @(posedge scl_in or negedge core_rst_n) begin
    if (!core_rst_n) twi_rdata <= 8'h00;
    else twi_rdata <= rd_q;
  end

  // The data line only ever pulls low.
  assign sda_out = 1'b0;
  assign sda_oe_n_out = sda_oe_n;

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      interrupt_n_out         <= 1'b1;
      module_absent_out       <= 1'b0;
      receive_signal_lost_out <= 1'b1;
    end else begin
      interrupt_n_out         <= ~(|alarm || |warn);
      module_absent_out       <= 1'b0;
      receive_signal_lost_out <= ~sig_s[1];
    end
  end

  // Laser switches off at once; it switches on after the enable level has been steady for the period.
  logic [CW-1:0] tx_cnt;
  always_ff @(posedge ref_clk_in or negedge core_rst_n) begin
    if (!core_rst_n) begin
      tx_cnt       <= '0;
      laser_on_out <= 1'b0;
    end else if (txoff_s[1] || standby_out) begin
      tx_cnt       <= '0;
      laser_on_out <= 1'b0;
    end else if (tx_cnt < CW'(TX_SWITCH_CYCLES - 1)) begin
      tx_cnt <= tx_cnt + 1'b1;
    end else begin
      laser_on_out <= 1'b1;
    end
  end

endmodule

//--- verif/omm_top_props.sv
// Purpose: Timing relations at the pins of the management port.
// Assumes: Serial clock is sampled here as data on the core clock.
// Notes:   Long transmitter counts are checked through helper counters.
`timescale 1ns/1ps
module omm_top_props #(
  parameter int unsigned TX_SWITCH_CYCLES = 20
) (
  // Clock and reset
  input wire logic                ref_clk_in,
  input wire logic                nrst_in,
  // Control pins
  input wire logic                deselect_in,
  input wire logic                transmitter_off_in,
  input wire logic                power_down_in,
  input wire logic                optical_signal_in,
  input wire omm_pkg::omm_mon_s   monitor_in,
  input wire omm_pkg::omm_limit_s limits_in [omm_pkg::N_MON],
  // Bus and status pins
  input wire logic                scl_in,
  input wire logic                sda_oe_n_out,
  input wire logic                interrupt_n_out,
  input wire logic                module_absent_out,
  input wire logic                receive_signal_lost_out,
  input wire logic                laser_on_out,
  input wire logic                standby_out
);
  // Margin covers the input synchronisers on top of the switch count.
  localparam int LIMIT = TX_SWITCH_CYCLES + 8;
  int off_cnt;
  int on_cnt;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) off_cnt <= 0;
    else if (transmitter_off_in && laser_on_out) off_cnt <= off_cnt + 1;
    else off_cnt <= 0;
  end
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) on_cnt <= 0;
    else if (!transmitter_off_in && !power_down_in && !laser_on_out)
      on_cnt <= on_cnt + 1;
    else on_cnt <= 0;
  end
  absent_tied_a: assert property (module_absent_out == 1'b0)
    else $error("absent pin not low");
  loss_set_a: assert property ((!optical_signal_in) [*6]
    |-> receive_signal_lost_out) else $error("loss not reported");
  loss_clear_a: assert property (optical_signal_in [*6]
    |-> !receive_signal_lost_out) else $error("loss stuck high");
  laser_off_time_a: assert property (off_cnt <= LIMIT)
    else $error("laser stays on too long");
  laser_on_time_a: assert property (on_cnt <= LIMIT)
    else $error("laser stays off too long");
  standby_dark_a: assert property (standby_out |-> !laser_on_out)
    else $error("laser on in standby");
  standby_hold_a: assert property (power_down_in [*4] |-> standby_out)
    else $error("standby missing");
  reset_pulse_a: assert property ($fell(power_down_in)
    |-> ##[1:6] (!standby_out && !laser_on_out))
    else $error("no restart after power down");
  alarm_intr_a: assert property ((monitor_in.temp > limits_in[0].hi) [*4]
    |-> !interrupt_n_out) else $error("interrupt missing");
  desel_quiet_a: assert property (deselect_in [*6] |-> sda_oe_n_out)
    else $error("bus driven while deselected");
  drive_edge_a: assert property ($fell(sda_oe_n_out) |-> !scl_in)
    else $error("data line changed with clock high");
endmodule
bind omm_top omm_top_props #(.TX_SWITCH_CYCLES(TX_SWITCH_CYCLES)) u_props (
  .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .deselect_in(deselect_in),
  .transmitter_off_in(transmitter_off_in), .power_down_in(power_down_in),
  .optical_signal_in(optical_signal_in), .monitor_in(monitor_in),
  .limits_in(limits_in), .scl_in(scl_in), .sda_oe_n_out(sda_oe_n_out),
  .interrupt_n_out(interrupt_n_out), .module_absent_out(module_absent_out),
  .receive_signal_lost_out(receive_signal_lost_out),
  .laser_on_out(laser_on_out), .standby_out(standby_out));

//--- verif/omm_host_model.sv
// Purpose: Host board master of the two-wire bus.
// Assumes: Data line has a pull-up; the clock stands high between frames.
// Notes:   Clock low phase is held long enough for the core to answer.
`timescale 1ns/1ps
module omm_host_model (
  // Bus lines
  output logic      scl_out,
  output logic      sda_out,
  // Module side of the data line
  input  wire logic sda_oe_n_in,
  input  wire logic sda_drv_in
);
  logic rel = 1'b1;
  // Wired-and of both drivers with the pull-up.
  assign sda_out = rel & (sda_oe_n_in | sda_drv_in);
  initial scl_out = 1'b1;
  task automatic bit_io(input logic b, output logic r);
    rel = b;
    #80;
    scl_out = 1'b1;
    #20;
    r = sda_out;
    #20;
    scl_out = 1'b0;
  endtask
  task automatic start();
    rel = 1'b1;
    #40;
    scl_out = 1'b1;
    #40;
    rel = 1'b0;
    #40;
    scl_out = 1'b0;
  endtask
  task automatic stop();
    rel = 1'b0;
    #40;
    scl_out = 1'b1;
    #40;
    rel = 1'b1;
    #40;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic recv_byte(output logic [7:0] d, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule

//--- verif/optical_module_mgmt_port_test.sv
// Purpose: Self-checking bench of the management port.
// Assumes: Host model owns the serial lines; pins step after clock edges.
// Notes:   Transmitter switch count is shortened to 20 core cycles.
`timescale 1ns/1ps
module optical_module_mgmt_port_test;
  logic                ref_clk_in = 1'b0;
  logic                nrst_in = 1'b0;
  logic                desel = 1'b0;
  logic                tx_off = 1'b0;
  logic                pdown = 1'b0;
  logic                optic = 1'b1;
  omm_pkg::omm_mon_s   mon = 40'h7C7D7E7F80;
  omm_pkg::omm_limit_s lim [omm_pkg::N_MON];
  logic                scl, sda, sda_drv, oe_n, intr_n, absent;
  logic                lost, laser, stby, k;
  logic [7:0]          buf_b [8];
  logic [7:0]          got_b [8];
  int                  num_errors = 0;
  int                  checks_done = 0;
  always #10 ref_clk_in = ~ref_clk_in;
  initial for (int i = 0; i < omm_pkg::N_MON; i++) lim[i] = 16'hF010;
  omm_top #(.TX_SWITCH_CYCLES(20), .MEM_DEPTH(256)) DUT (
    .ref_clk_in(ref_clk_in), .nrst_in(nrst_in), .deselect_in(desel),
    .transmitter_off_in(tx_off), .power_down_in(pdown),
    .optical_signal_in(optic), .monitor_in(mon), .limits_in(lim),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_drv), .sda_oe_n_out(oe_n),
    .interrupt_n_out(intr_n), .module_absent_out(absent),
    .receive_signal_lost_out(lost), .laser_on_out(laser),
    .standby_out(stby));
  omm_host_model h (.scl_out(scl), .sda_out(sda), .sda_oe_n_in(oe_n),
    .sda_drv_in(sda_drv));
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return laser;
      1: return intr_n;
      2: return lost;
      default: return stby;
    endcase
  endfunction
  task automatic await(input int w, input logic v);
    int i;
    for (i = 0; i < 200 && pick(w) !== v; i++) step(1);
    check({7'h0, pick(w)}, {7'h0, v});
    if (i == 200) tally_and_finish();
  endtask
  task automatic wr(input logic [7:0] a, input int n);
    h.start();
    h.send_byte(8'hA0, k);
    check({7'h0, k}, 8'h01);
    h.send_byte(a, k);
    check({7'h0, k}, 8'h01);
    for (int i = 0; i < n; i++) begin
      h.send_byte(buf_b[i], k);
      check({7'h0, k}, 8'h01);
    end
    h.stop();
  endtask
  task automatic rd(input logic [7:0] a, input int n);
    h.start();
    h.send_byte(8'hA0, k);
    h.send_byte(a, k);
    h.start();
    h.send_byte(8'hA1, k);
    for (int i = 0; i < n; i++) h.recv_byte(got_b[i], i == n - 1);
    h.stop();
  endtask
  task automatic cmp(input int n);
    for (int i = 0; i < n; i++) check(got_b[i], buf_b[i]);
  endtask
  initial begin
    step(4);
    nrst_in = 1'b1;
    check({7'h0, absent}, 8'h00);
    await(0, 1'b1);
    for (int i = 0; i < 5; i++) buf_b[i] = mon[39 - 8 * i -: 8];
    rd(omm_pkg::ADDR_TEMP, 5);
    cmp(5);
    buf_b[0] = 8'hFF;
    wr(omm_pkg::ADDR_TEMP, 1);
    rd(omm_pkg::ADDR_TEMP, 1);
    buf_b[0] = mon.temp;
    cmp(1);
    buf_b[0] = 8'h5A;
    buf_b[1] = 8'hA5;
    wr(8'h80, 2);
    rd(8'h80, 2);
    cmp(2);
    step(1);
    desel = 1'b1;
    step(4);
    h.start();
    h.send_byte(8'hA0, k);
    h.stop();
    check({7'h0, k}, 8'h00);
    step(1);
    desel = 1'b0;
    mon.temp = 8'hFA;
    await(1, 1'b0);
    rd(omm_pkg::ADDR_ALARM, 1);
    check({7'h0, got_b[0] !== 8'h00}, 8'h01);
    step(1);
    mon.temp = 8'h7C;
    await(1, 1'b1);
    optic = 1'b0;
    await(2, 1'b1);
    optic = 1'b1;
    await(2, 1'b0);
    tx_off = 1'b1;
    await(0, 1'b0);
    tx_off = 1'b0;
    await(0, 1'b1);
    pdown = 1'b1;
    await(3, 1'b1);
    await(0, 1'b0);
    pdown = 1'b0;
    await(3, 1'b0);
    rd(8'h80, 1);
    check(got_b[0], 8'h00);
    buf_b[0] = 8'h3C;
    wr(8'h90, 1);
    rd(8'h90, 1);
    cmp(1);
    step(1);
    await(0, 1'b1);
    tally_and_finish();
  end
endmodule
